// [fsk_pkg.sv]
package fsk_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] FSK_IDX_CTRL = 8'h01;
  localparam logic [7:0] FSK_IDX_LIMITS = 8'h02;
  localparam logic [7:0] FSK_IDX_FLAGS1 = 8'h3e;
  localparam logic [7:0] FSK_IDX_FLAGS2 = 8'h3f;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int FSK_CTRL_MODE_LSB = 0;
  localparam int FSK_CTRL_CONT_BIT = 3;
  localparam int FSK_CTRL_CRC_BIT = 4;
  localparam int FSK_CTRL_KEEP_BIT = 5;
  localparam int FSK_CTRL_SUPPLY_LOW_FLAG_BIT = 6;

  // Limits register fields.
  localparam int FSK_LIM_QUEUE_LSB = 0;
  localparam int FSK_LIM_SIGNAL_LSB = 8;

  // ------------------------------------------------------------
  // Flag bit positions within the two flag registers
  // ------------------------------------------------------------
  localparam int FSK_F1_MODE = 7;
  localparam int FSK_F1_RX = 6;
  localparam int FSK_F1_TX = 5;
  localparam int FSK_F1_LOCK = 4;
  localparam int FSK_F1_RSSI = 3;
  localparam int FSK_F1_TIMEOUT = 2;
  localparam int FSK_F1_PREAMBLE = 1;
  localparam int FSK_F1_SYNC = 0;
  localparam int FSK_F2_FULL = 7;
  localparam int FSK_F2_EMPTY = 6;
  localparam int FSK_F2_LEVEL = 5;
  localparam int FSK_F2_OVERRUN = 4;
  localparam int FSK_F2_SENT = 3;
  localparam int FSK_F2_PAYLOAD = 2;
  localparam int FSK_F2_CHECK = 1;
  localparam int FSK_F2_SUPPLY = 0;

  // Sticky flag cell numbering.
  localparam int FSK_CELLS = 11;
  localparam int FSK_C_MODE = 0;
  localparam int FSK_C_RX = 1;
  localparam int FSK_C_TX = 2;
  localparam int FSK_C_RSSI = 3;
  localparam int FSK_C_TIMEOUT = 4;
  localparam int FSK_C_PREAMBLE = 5;
  localparam int FSK_C_SYNC = 6;
  localparam int FSK_C_OVERRUN = 7;
  localparam int FSK_C_SENT = 8;
  localparam int FSK_C_PAYLOAD = 9;
  localparam int FSK_C_CHECK = 10;
  localparam int FSK_C_SUPPLY = 11;

  // ------------------------------------------------------------
  // Queue figures and reset values
  // ------------------------------------------------------------
  localparam logic [6:0] FSK_QUEUE_DEPTH = 7'h42;
  localparam logic [6:0] FSK_QUEUE_LIMIT_RESET = 7'h0f;
  localparam logic [7:0] FSK_SIGNAL_LIMIT_RESET = 8'hff;

  // Operating modes, Gray coded along sleep, standby, synth, rx, tx.
  typedef enum logic [2:0] {
    FSK_MODE_SLEEP = 3'h0,
    FSK_MODE_STANDBY = 3'h1,
    FSK_MODE_SYNTH = 3'h3,
    FSK_MODE_RX = 3'h2,
    FSK_MODE_TX = 3'h6
  } fsk_mode_type;

  // Software configuration.
  typedef struct packed {
    logic supply_low_flag_en;
    logic keep_payload_on_check_fail;
    logic crc_en;
    logic continuous;
    fsk_mode_type mode;
  } fsk_config_type;

  // Events and levels from the modem datapaths.
  typedef struct packed {
    logic xo_running;
    logic pll_locked;
    logic rssi_sampling;
    logic rx_settled;
    logic pa_ramp_done;
    logic timeout;
    logic preamble_found;
    logic sync_addr_hit;
    logic queue_overrun;
    logic frame_done;
    logic last_byte;
    logic check_ok;
    logic battery_below;
  } fsk_events_type;

endpackage

// [fsk_flag_cell.sv]
`timescale 1ns/1ps

// Sticky flag: a set in the same cycle as a clear wins.
module fsk_flag_cell (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic set_in,
  input wire logic clear_in,
  // Flag
  output logic flag_out
);

  logic next_flag;

  // Next value of the flag.
  always_comb begin
    next_flag = set_in | (flag_out & ~clear_in);
  end

  // Flag register.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule

// [fsk_mode_track.sv]
`timescale 1ns/1ps

// Remembers the last mode and pulses when the requested mode changes.
module fsk_mode_track
  import fsk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Requested mode
  input fsk_mode_type mode_in,
  // Change events, one cycle each
  output logic change_out,
  output logic left_rx_out,
  output logic left_tx_out
);

  fsk_mode_type prev_mode;
  fsk_mode_type next_prev_mode;

  // Next value of the remembered mode.
  always_comb begin
    next_prev_mode = mode_in;
  end

  // Mode history register.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_mode <= FSK_MODE_SLEEP;
    end else begin
      prev_mode <= next_prev_mode;
    end
  end

  // Change decode against the previous mode.
  assign change_out = (mode_in != prev_mode);
  assign left_rx_out = change_out && (prev_mode == FSK_MODE_RX);
  assign left_tx_out = change_out && (prev_mode == FSK_MODE_TX);

endmodule

// [fsk_irq_status_flags.sv]
`timescale 1ns/1ps

module fsk_irq_status_flags
  import fsk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Modem datapath
  input fsk_events_type events_in,
  input wire logic [7:0] signal_strength_value_in,
  input wire logic [6:0] queue_count_in,
  // Configuration and status towards the modem
  output fsk_config_type config_out,
  output logic [6:0] queue_level_limit_out,
  output logic [7:0] signal_strength_limit_out,
  output logic queue_flush_out,
  // Flag registers
  output logic [7:0] flags_mode_out,
  output logic [7:0] flags_queue_out
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------

  logic [7:0] bus_index;
  logic bus_aligned;
  logic bus_setup;
  logic bus_write;
  logic hit_ctrl;
  logic hit_limits;
  logic hit_flags1;
  logic hit_flags2;
  logic hit_any;

  assign bus_index = paddr_in[9:2];
  assign bus_aligned = (paddr_in[1:0] == 2'h0);
  assign bus_setup = psel_in && !penable_in;
  // A write takes effect only at the completing edge of the access.
  assign bus_write = psel_in && penable_in && pready_out && pwrite_in;

  // Register select by index.
  always_comb begin
    hit_ctrl = 1'b0;
    hit_limits = 1'b0;
    hit_flags1 = 1'b0;
    hit_flags2 = 1'b0;
    if (!bus_aligned) begin
      hit_ctrl = 1'b0;
    end else if (bus_index == FSK_IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (bus_index == FSK_IDX_LIMITS) begin
      hit_limits = 1'b1;
    end else if (bus_index == FSK_IDX_FLAGS1) begin
      hit_flags1 = 1'b1;
    end else if (bus_index == FSK_IDX_FLAGS2) begin
      hit_flags2 = 1'b1;
    end
  end

  assign hit_any = hit_ctrl | hit_limits | hit_flags1 | hit_flags2;

  // ------------------------------------------------------------
  // Bus answer: ready one cycle after setup, data and error registered
  // ------------------------------------------------------------

  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] read_word;

  // Read multiplexer; reading has no side effect.
  always_comb begin
    read_word = 32'h0;
    if (hit_ctrl) begin
      read_word[6:0] = config_out;
    end else if (hit_limits) begin
      read_word[FSK_LIM_QUEUE_LSB +: 7] = queue_level_limit_out;
      read_word[FSK_LIM_SIGNAL_LSB +: 8] = signal_strength_limit_out;
    end else if (hit_flags1) begin
      read_word[7:0] = flags_mode_out;
    end else if (hit_flags2) begin
      read_word[7:0] = flags_queue_out;
    end
  end

  // Answer computed in the setup cycle and shown in the access cycle.
  always_comb begin
    next_pready = bus_setup;
    next_pslverr = bus_setup && !hit_any;
    next_prdata = prdata_out;
    if (bus_setup && !pwrite_in) begin
      next_prdata = read_word;
    end
  end

  // Bus answer registers.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------

  fsk_config_type next_config;
  logic [6:0] next_queue_limit;
  logic [7:0] next_signal_limit;
  logic [2:0] wr_mode;

  assign wr_mode = pwdata_in[FSK_CTRL_MODE_LSB +: 3];

  // Software writes; an unknown mode code leaves the mode unchanged.
  always_comb begin
    next_config = config_out;
    next_queue_limit = queue_level_limit_out;
    next_signal_limit = signal_strength_limit_out;
    if (bus_write && hit_ctrl) begin
      next_config.continuous = pwdata_in[FSK_CTRL_CONT_BIT];
      next_config.crc_en = pwdata_in[FSK_CTRL_CRC_BIT];
      next_config.keep_payload_on_check_fail = pwdata_in[FSK_CTRL_KEEP_BIT];
      next_config.supply_low_flag_en = pwdata_in[FSK_CTRL_SUPPLY_LOW_FLAG_BIT];
      case (wr_mode)
        FSK_MODE_SLEEP: next_config.mode = FSK_MODE_SLEEP;
        FSK_MODE_STANDBY: next_config.mode = FSK_MODE_STANDBY;
        FSK_MODE_SYNTH: next_config.mode = FSK_MODE_SYNTH;
        FSK_MODE_RX: next_config.mode = FSK_MODE_RX;
        FSK_MODE_TX: next_config.mode = FSK_MODE_TX;
        default: next_config.mode = config_out.mode;
      endcase
    end
    if (bus_write && hit_limits) begin
      next_queue_limit = pwdata_in[FSK_LIM_QUEUE_LSB +: 7];
      next_signal_limit = pwdata_in[FSK_LIM_SIGNAL_LSB +: 8];
    end
  end

  // Configuration storage.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_out <= '{supply_low_flag_en: 1'b0, keep_payload_on_check_fail: 1'b0,
                      crc_en: 1'b0, continuous: 1'b0, mode: FSK_MODE_SLEEP};
      queue_level_limit_out <= FSK_QUEUE_LIMIT_RESET;
      signal_strength_limit_out <= FSK_SIGNAL_LIMIT_RESET;
    end else begin
      config_out <= next_config;
      queue_level_limit_out <= next_queue_limit;
      signal_strength_limit_out <= next_signal_limit;
    end
  end

  // ------------------------------------------------------------
  // Mode history and queue emptying
  // ------------------------------------------------------------

  logic mode_change;
  logic left_rx;
  logic left_tx;
  logic in_rx;
  logic in_tx;
  logic w1c_mode;
  logic w1c_queue;
  logic queue_emptied;
  logic [6:0] prev_count;
  logic [6:0] next_prev_count;
  logic next_flush;

  fsk_mode_track u_mode_track (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .mode_in(config_out.mode),
    .change_out(mode_change),
    .left_rx_out(left_rx),
    .left_tx_out(left_tx)
  );

  assign in_rx = (config_out.mode == FSK_MODE_RX);
  assign in_tx = (config_out.mode == FSK_MODE_TX);
  assign w1c_mode = bus_write && hit_flags1;
  assign w1c_queue = bus_write && hit_flags2;

  // The queue counts as emptied when its count drops to zero or on a flush.
  assign queue_emptied = ((prev_count != 7'h0) && (queue_count_in == 7'h0)) ||
                         queue_flush_out;

  // Writing one to the overrun flag flushes the queue for one cycle.
  always_comb begin
    next_prev_count = queue_count_in;
    next_flush = w1c_queue && pwdata_in[FSK_F2_OVERRUN];
  end

  // Queue history and flush strobe.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_count <= 7'h0;
      queue_flush_out <= 1'b0;
    end else begin
      prev_count <= next_prev_count;
      queue_flush_out <= next_flush;
    end
  end

  // ------------------------------------------------------------
  // Sticky flag set and clear terms
  // ------------------------------------------------------------

  logic [FSK_CELLS:0] cell_set;
  logic [FSK_CELLS:0] cell_clear;
  logic [FSK_CELLS:0] cell_flag;
  logic mode_ready;
  logic payload_ok;

  // Readiness of the currently requested mode.
  always_comb begin
    case (config_out.mode)
      FSK_MODE_SLEEP: mode_ready = 1'b1;
      FSK_MODE_STANDBY: mode_ready = events_in.xo_running;
      FSK_MODE_SYNTH: mode_ready = events_in.pll_locked;
      FSK_MODE_RX: mode_ready = events_in.rssi_sampling;
      FSK_MODE_TX: mode_ready = events_in.pa_ramp_done;
      default: mode_ready = 1'b0;
    endcase
  end

  // The check gates the payload only with check on and retention off.
  assign payload_ok = !config_out.crc_en || config_out.keep_payload_on_check_fail ||
                      events_in.check_ok;

  // Set terms; a clear bit written as zero or to a read-only flag is ignored.
  always_comb begin
    cell_set = '0;
    cell_clear = '0;
    cell_set[FSK_C_MODE] = mode_ready;
    cell_clear[FSK_C_MODE] = mode_change;
    cell_set[FSK_C_RX] = in_rx && events_in.rx_settled;
    cell_clear[FSK_C_RX] = left_rx;
    cell_set[FSK_C_TX] = in_tx && events_in.pa_ramp_done;
    cell_clear[FSK_C_TX] = left_tx;
    cell_set[FSK_C_RSSI] = in_rx &&
                           (signal_strength_value_in > signal_strength_limit_out);
    cell_clear[FSK_C_RSSI] = left_rx || (w1c_mode && pwdata_in[FSK_F1_RSSI]);
    cell_set[FSK_C_TIMEOUT] = events_in.timeout;
    cell_clear[FSK_C_TIMEOUT] = left_rx || queue_emptied;
    cell_set[FSK_C_PREAMBLE] = events_in.preamble_found;
    cell_clear[FSK_C_PREAMBLE] = w1c_mode && pwdata_in[FSK_F1_PREAMBLE];
    cell_set[FSK_C_SYNC] = events_in.sync_addr_hit;
    cell_clear[FSK_C_SYNC] = left_rx || queue_emptied ||
                             (config_out.continuous && w1c_mode &&
                              pwdata_in[FSK_F1_SYNC]);
    cell_set[FSK_C_OVERRUN] = events_in.queue_overrun &&
                              (config_out.mode != FSK_MODE_SLEEP);
    cell_clear[FSK_C_OVERRUN] = w1c_queue && pwdata_in[FSK_F2_OVERRUN];
    cell_set[FSK_C_SENT] = in_tx && events_in.frame_done;
    cell_clear[FSK_C_SENT] = left_tx;
    cell_set[FSK_C_PAYLOAD] = in_rx && events_in.last_byte && payload_ok;
    cell_clear[FSK_C_PAYLOAD] = queue_emptied;
    cell_set[FSK_C_CHECK] = in_rx && events_in.check_ok;
    cell_clear[FSK_C_CHECK] = queue_emptied;
    cell_set[FSK_C_SUPPLY] = config_out.supply_low_flag_en && events_in.battery_below;
    cell_clear[FSK_C_SUPPLY] = w1c_queue && pwdata_in[FSK_F2_SUPPLY];
  end

  // One sticky cell per event flag.
  genvar g;
  generate
    for (g = 0; g <= FSK_CELLS; g++) begin : g_cell
      fsk_flag_cell u_cell (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .set_in(cell_set[g]),
        .clear_in(cell_clear[g]),
        .flag_out(cell_flag[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Level flags that follow their source
  // ------------------------------------------------------------

  logic lock_flag;
  logic full_flag;
  logic empty_flag;
  logic above_flag;
  logic next_lock;
  logic next_full;
  logic next_empty;
  logic next_above;

  // Level conditions sampled every cycle.
  always_comb begin
    next_lock = (config_out.mode == FSK_MODE_SYNTH || in_rx || in_tx) &&
                events_in.pll_locked;
    next_full = (queue_count_in == FSK_QUEUE_DEPTH);
    next_empty = (queue_count_in == 7'h0);
    next_above = (queue_count_in > queue_level_limit_out);
  end

  // Level flag registers; the queue starts empty.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_flag <= 1'b0;
      full_flag <= 1'b0;
      empty_flag <= 1'b1;
      above_flag <= 1'b0;
    end else begin
      lock_flag <= next_lock;
      full_flag <= next_full;
      empty_flag <= next_empty;
      above_flag <= next_above;
    end
  end

  // ------------------------------------------------------------
  // Flag register assembly, all bits straight from flip-flops
  // ------------------------------------------------------------

  always_comb begin
    flags_mode_out = 8'h0;
    flags_mode_out[FSK_F1_MODE] = cell_flag[FSK_C_MODE];
    flags_mode_out[FSK_F1_RX] = cell_flag[FSK_C_RX];
    flags_mode_out[FSK_F1_TX] = cell_flag[FSK_C_TX];
    flags_mode_out[FSK_F1_LOCK] = lock_flag;
    flags_mode_out[FSK_F1_RSSI] = cell_flag[FSK_C_RSSI];
    flags_mode_out[FSK_F1_TIMEOUT] = cell_flag[FSK_C_TIMEOUT];
    flags_mode_out[FSK_F1_PREAMBLE] = cell_flag[FSK_C_PREAMBLE];
    flags_mode_out[FSK_F1_SYNC] = cell_flag[FSK_C_SYNC];
    flags_queue_out = 8'h0;
    flags_queue_out[FSK_F2_FULL] = full_flag;
    flags_queue_out[FSK_F2_EMPTY] = empty_flag;
    flags_queue_out[FSK_F2_LEVEL] = above_flag;
    flags_queue_out[FSK_F2_OVERRUN] = cell_flag[FSK_C_OVERRUN];
    flags_queue_out[FSK_F2_SENT] = cell_flag[FSK_C_SENT];
    flags_queue_out[FSK_F2_PAYLOAD] = cell_flag[FSK_C_PAYLOAD];
    flags_queue_out[FSK_F2_CHECK] = cell_flag[FSK_C_CHECK];
    flags_queue_out[FSK_F2_SUPPLY] = cell_flag[FSK_C_SUPPLY];
  end

endmodule

// [fsk_host_model.sv]
`timescale 1ns/1ps

// Host on the register bus: one APB transfer at a time.
module fsk_host_model (
  // Clock
  input wire logic clk_in,
  // Answer from the block
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  // Request to the block
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [9:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // The bus starts idle.
  initial begin
    {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  end

  // Setup, then access until ready; address and data lines then show the inverse.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

// [fsk_irq_status_flags_chk.sv]
`timescale 1ns/1ps

// Watches the flag registers against their causes.
module fsk_irq_status_flags_chk
  import fsk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  // Modem side and flags
  input fsk_events_type events_in,
  input wire logic [7:0] signal_strength_value_in,
  input wire logic [6:0] queue_count_in,
  input fsk_config_type config_out,
  input wire logic [6:0] queue_level_limit_out,
  input wire logic [7:0] signal_strength_limit_out,
  input wire logic queue_flush_out,
  input wire logic [7:0] flags_mode_out,
  input wire logic [7:0] flags_queue_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // Completed flag writes and ready causes.
  wire logic wr = psel_in && penable_in && pwrite_in && pready_out;
  wire logic wr_1 = wr && paddr_in == 10'h0f8;
  wire logic wr_2 = wr && paddr_in == 10'h0fc;
  wire logic rdy = events_in.xo_running || events_in.pll_locked || events_in.rssi_sampling ||
    events_in.pa_ramp_done;
  wire logic in_rx = config_out.mode == FSK_MODE_RX;

  mode_clear_a: assert property (
    $changed(config_out.mode) && config_out.mode != FSK_MODE_SLEEP && !rdy
    |-> ##[1:2] !flags_mode_out[7]) else $error("mode flag kept");
  lock_follow_a: assert property (
    config_out.mode inside {FSK_MODE_SYNTH, FSK_MODE_RX, FSK_MODE_TX} && $stable(config_out.mode)
    |=> flags_mode_out[4] == $past(events_in.pll_locked)) else $error("lock flag wrong");
  rssi_set_a: assert property (
    in_rx && $stable(config_out.mode) && signal_strength_value_in > signal_strength_limit_out
    |=> flags_mode_out[3]) else $error("rssi flag not set");
  preamble_keep_a: assert property (
    flags_mode_out[1] && !(wr_1 && pwdata_in[1]) |=> flags_mode_out[1])
    else $error("preamble flag lost");
  full_flag_a: assert property (
    1'b1 |=> flags_queue_out[7] == ($past(queue_count_in) == FSK_QUEUE_DEPTH))
    else $error("full flag wrong");
  level_flag_a: assert property (
    1'b1 |=> flags_queue_out[5] == ($past(queue_count_in) > $past(queue_level_limit_out)))
    else $error("level flag wrong");
  flush_pulse_a: assert property (
    wr_2 && pwdata_in[4] |-> ##[1:2] queue_flush_out) else $error("no flush");
  supply_hold_a: assert property (
    $fell(flags_queue_out[0]) |-> $past(wr_2 && pwdata_in[0])) else $error("supply flag dropped");
  supply_off_a: assert property (
    !config_out.supply_low_flag_en && !flags_queue_out[0] |=> !flags_queue_out[0])
    else $error("supply flag while off");

  // Main scenarios.
  cover property (wr_2 && pwdata_in[4]);
  cover property (flags_queue_out[7]);
  cover property ($fell(flags_queue_out[0]));
endmodule

// [tb_fsk_irq_status_flags.sv]
`timescale 1ns/1ps

// Self-checking bench for the flag block.
module tb_fsk_irq_status_flags;
  import fsk_pkg::*;
  localparam logic [9:0] A_CTRL = {FSK_IDX_CTRL, 2'h0};
  localparam logic [9:0] A_LIM = {FSK_IDX_LIMITS, 2'h0};
  localparam logic [9:0] A_F1 = {FSK_IDX_FLAGS1, 2'h0};
  localparam logic [9:0] A_F2 = {FSK_IDX_FLAGS2, 2'h0};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, flush;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  fsk_events_type ev = '0;
  logic [7:0] sig = 8'h00;
  logic [6:0] cnt = 7'h00;
  logic [7:0] fm, fq;
  int err_count = 0;
  int num_checks = 0;
  int flushes = 0;

  // Block under test and its bus host.
  fsk_irq_status_flags uut (.clk_in, .reset_n_in, .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .events_in(ev),
    .signal_strength_value_in(sig), .queue_count_in(cnt), .config_out(),
    .queue_level_limit_out(), .signal_strength_limit_out(), .queue_flush_out(flush),
    .flags_mode_out(fm), .flags_queue_out(fq));
  fsk_host_model host (.clk_in, .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));

  // Clock, flush pulse counter and watchdog.
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (flush === 1'b1) flushes <= flushes + 1;
  initial begin
    #40000;
    err_count++;
    close_out();
  end

  // Comparison and report helpers.
  task automatic chk(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Stimulus helpers.
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
    wait_n(2);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge clk_in) ev <= ev | m;
    @(posedge clk_in) ev <= ev & ~m;
    #1;
  endtask
  task automatic mode_set(input fsk_mode_type m, input logic [3:0] o);
    wr(A_CTRL, {25'h0, o, m});
    wait_n(1);
  endtask
  task automatic empty_q();
    @(posedge clk_in) cnt <= 7'h03;
    @(posedge clk_in) cnt <= 7'h00;
    wait_n(2);
  endtask

  // Register bus answers, reset value and refusals.
  task automatic t_bus();
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, A_F2, 32'h0, q, e);
    chk("reset queue flags", 1'b1, q === 32'h40);
    host.xfer(1'b0, A_F2, 32'h0, q, e);
    chk("second read", 1'b1, q === 32'h40);
    host.xfer(1'b0, A_LIM, 32'h0, q, e);
    chk("limit reset", 1'b1, q === 32'hff0f);
    host.xfer(1'b0, 10'h010, 32'h0, q, e);
    chk("unmapped", 1'b1, e === 1'b1 && q === 32'h0);
    host.xfer(1'b1, A_F1 | 10'h001, 32'hff, q, e);
    chk("misaligned", 1'b1, e);
    $display("bus done");
  endtask

  // Mode ready, lock, transmit flags.
  task automatic t_mode();
    chk("sleep ready", 1'b1, fm[7]);
    mode_set(FSK_MODE_STANDBY, 4'h0);
    chk("standby wait", 1'b0, fm[7]);
    @(posedge clk_in) ev.xo_running <= 1'b1;
    wait_n(2);
    chk("standby ready", 1'b1, fm[7]);
    @(posedge clk_in) ev.pll_locked <= 1'b1;
    mode_set(FSK_MODE_SYNTH, 4'h0);
    chk("synth ready", 1'b1, fm[7]);
    chk("lock", 1'b1, fm[4]);
    @(posedge clk_in) ev.pll_locked <= 1'b0;
    wait_n(2);
    chk("unlock", 1'b0, fm[4]);
    mode_set(FSK_MODE_TX, 4'h0);
    chk("tx wait", 1'b0, fm[7]);
    pulse(13'h100);
    chk("tx ready", 1'b1, fm[5] & fm[7]);
    pulse(13'h008);
    chk("sent", 1'b1, fq[3]);
    mode_set(FSK_MODE_STANDBY, 4'h0);
    chk("tx left", 1'b0, fm[5] | fq[3]);
    $display("mode done");
  endtask

  // Receive flags, empty and leave clears, check gating.
  task automatic t_rx();
    mode_set(FSK_MODE_RX, 4'h0);
    pulse(13'h400);
    chk("rx reached", 1'b1, fm[7]);
    chk("rx early", 1'b0, fm[6]);
    pulse(13'h200);
    chk("rx ready", 1'b1, fm[6]);
    wr(A_LIM, 32'h7f0f);
    @(posedge clk_in) sig <= 8'h7f;
    wait_n(2);
    chk("rssi at limit", 1'b0, fm[3]);
    @(posedge clk_in) sig <= 8'h80;
    wait_n(2);
    chk("rssi over", 1'b1, fm[3]);
    @(posedge clk_in) sig <= 8'h00;
    wr(A_F1, 32'h08);
    chk("rssi clear", 1'b0, fm[3]);
    pulse(13'h0a0);
    wr(A_F1, 32'h01);
    chk("timeout", 1'b1, fm[2]);
    chk("sync read only", 1'b1, fm[0]);
    empty_q();
    chk("emptied", 1'b0, fm[2] | fm[0]);
    mode_set(FSK_MODE_RX, 4'h1);
    pulse(13'h020);
    wr(A_F1, 32'h01);
    chk("sync w1c", 1'b0, fm[0]);
    mode_set(FSK_MODE_RX, 4'h2);
    pulse(13'h004);
    chk("payload gated", 1'b0, fq[2]);
    pulse(13'h006);
    chk("payload check", 1'b1, fq[2] & fq[1]);
    empty_q();
    chk("payload emptied", 1'b0, fq[2] | fq[1]);
    mode_set(FSK_MODE_RX, 4'h6);
    pulse(13'h0a4);
    chk("payload kept", 1'b1, fq[2]);
    mode_set(FSK_MODE_STANDBY, 4'h0);
    chk("rx left", 1'b0, fm[6] | fm[2] | fm[0]);
    $display("rx done");
  endtask

  // Queue level flags, overrun and flush.
  task automatic t_queue();
    logic [6:0] tbl [6] = '{7'h00, 7'h01, 7'h10, 7'h11, 7'h41, 7'h42};
    int n;
    wr(A_LIM, 32'hff10);
    foreach (tbl[i]) begin
      @(posedge clk_in) cnt <= tbl[i];
      wait_n(2);
      chk("full", tbl[i] == FSK_QUEUE_DEPTH, fq[7]);
      chk("empty", tbl[i] == 7'h00, fq[6]);
      chk("level", tbl[i] > 7'h10, fq[5]);
    end
    mode_set(FSK_MODE_SLEEP, 4'h0);
    pulse(13'h010);
    chk("overrun sleep", 1'b0, fq[4]);
    mode_set(FSK_MODE_STANDBY, 4'h0);
    pulse(13'h010);
    chk("overrun", 1'b1, fq[4]);
    n = flushes;
    wr(A_F2, 32'h10);
    chk("overrun clear", 1'b0, fq[4]);
    chk("flush", 1'b1, flushes == n + 1);
    @(posedge clk_in) cnt <= 7'h00;
    wait_n(2);
    $display("queue done");
  endtask

  // Write-one-to-clear flags.
  task automatic t_sticky();
    pulse(13'h040);
    wr(A_F1, 32'hfd);
    chk("preamble kept", 1'b1, fm[1] & fm[7]);
    wr(A_F1, 32'h02);
    chk("preamble clear", 1'b0, fm[1]);
    @(posedge clk_in) ev.battery_below <= 1'b1;
    wait_n(3);
    chk("supply off", 1'b0, fq[0]);
    mode_set(FSK_MODE_STANDBY, 4'h8);
    chk("supply low", 1'b1, fq[0]);
    @(posedge clk_in) ev.battery_below <= 1'b0;
    wr(A_F2, 32'h00);
    chk("supply kept", 1'b1, fq[0]);
    wr(A_F2, 32'h01);
    chk("supply clear", 1'b0, fq[0]);
    $display("sticky done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wait_n(2);
    t_bus();
    t_mode();
    t_rx();
    t_queue();
    t_sticky();
    close_out();
  end
endmodule

bind fsk_irq_status_flags fsk_irq_status_flags_chk chk_i (.clk_in, .reset_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .events_in,
  .signal_strength_value_in, .queue_count_in, .config_out, .queue_level_limit_out,
  .signal_strength_limit_out, .queue_flush_out, .flags_mode_out, .flags_queue_out);
